// >>> rtl/sartd_pkg.sv
// Package: register map, field layout and timing constants of the threshold and debounce block
package sartd_pkg;
    // Register offsets (page-local 8-bit addresses)
    localparam logic [7:0] OFS_PEN_DB = 8'h14;
    localparam logic [7:0] OFS_FLAGS = 8'h15;
    localparam logic [7:0] OFS_A1MAX_H = 8'h16;
    localparam logic [7:0] OFS_A1MAX_L = 8'h17;
    localparam logic [7:0] OFS_A1MIN_H = 8'h18;
    localparam logic [7:0] OFS_A1MIN_L = 8'h19;
    localparam logic [7:0] OFS_A2MAX_H = 8'h1A;
    localparam logic [7:0] OFS_A2MAX_L = 8'h1B;
    localparam logic [7:0] OFS_A2MIN_H = 8'h1C;
    localparam logic [7:0] OFS_A2MIN_L = 8'h1D;
    localparam logic [7:0] OFS_TMAX_H = 8'h1E;
    localparam logic [7:0] OFS_TMAX_L = 8'h1F;
    localparam logic [7:0] OFS_TMIN_H = 8'h20;
    localparam logic [7:0] OFS_TMIN_L = 8'h21;
    localparam logic [7:0] OFS_DIV = 8'h10;
    // Field positions
    localparam int ENA_BIT = 4;
    localparam int DB_CODE_LSB = 0;
    localparam int DB_CODE_W = 3;
    localparam int FLG_A1MAX = 5;
    localparam int FLG_A1MIN = 4;
    localparam int FLG_A2MAX = 3;
    localparam int FLG_A2MIN = 2;
    localparam int FLG_TMAX = 1;
    localparam int FLG_TMIN = 0;
    // Reset values
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [6:0] RST_DIV = 7'h01;
    // Timing: one debounce tick of the 1 MHz base is 8 us at code 001
    localparam int DB_BASE_US = 64;
    localparam int DB_TICKS = 8;
    localparam int DIV_ZERO_RATIO = 128;
    // Conversion source selector
    typedef enum logic [1:0] {
        SARTD_SRC_FIRST_AUX,
        SARTD_SRC_SECOND_AUX,
        SARTD_SRC_TEMP
    } sartd_src_e;
endpackage

// >>> rtl/sartd_cmp_if.sv
// Interface: one threshold comparison channel between the register file and the comparator
`timescale 1ns/100ps
interface sartd_cmp_if;
    logic max_en;
    logic min_en;
    logic [11:0] max_thr;
    logic [11:0] min_thr;
    logic [11:0] sample;
    logic strobe;
    logic hit_max;
    logic hit_min;
    modport owner (output max_en, min_en, max_thr, min_thr, sample, strobe,
        input hit_max, hit_min);
    modport cmp (input max_en, min_en, max_thr, min_thr, sample, strobe,
        output hit_max, hit_min);
endinterface

// >>> rtl/sartd_cmp.sv
// Threshold comparator for one measured channel
`timescale 1ns/100ps
module sartd_cmp (
    // Channel
    sartd_cmp_if.cmp ch
);
    import sartd_pkg::*;
    // Flag only on a finished conversion with the check enabled
    assign ch.hit_max = ch.strobe && ch.max_en && (ch.sample >= ch.max_thr);
    assign ch.hit_min = ch.strobe && ch.min_en && (ch.sample <= ch.min_thr);
endmodule

// >>> rtl/sartd_top.sv
// Pen-down debounce and SAR threshold flag block with its register window
`timescale 1ns/100ps
module sartd_top (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Time base select: 1 uses internal oscillator ticks
    input wire logic osc_sel,
    input wire logic osc_tick,
    // Pen detection
    input wire logic pen_raw,
    output logic pen_down,
    // Conversion results
    input wire logic conv_done,
    input wire sartd_pkg::sartd_src_e conv_src,
    input wire logic [11:0] conv_data,
    // Flags mirror
    output logic [5:0] flags
);
    import sartd_pkg::*;

    logic [7:0] regs_r [OFS_DIV:OFS_TMIN_L];
    logic [7:0] regs_nxt [OFS_DIV:OFS_TMIN_L];
    logic [5:0] flags_r, flags_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [2:0] pen_sync_r, pen_sync_nxt;
    logic pen_state_r, pen_state_nxt;
    logic [6:0] div_cnt_r, div_cnt_nxt;
    logic [9:0] pre_cnt_r, pre_cnt_nxt;
    logic [3:0] tick_cnt_r, tick_cnt_nxt;
    logic pen_out_r, pen_out_nxt;
    logic us_tick, db_tick;
    logic [2:0] code;
    logic [9:0] pre_len;
    logic [7:0] div_len;
    logic flag_read, reg_write;

    function automatic logic [11:0] thr(input logic [7:0] hi, input logic [7:0] lo);
        thr = {hi[3:0], lo};
    endfunction

    function automatic logic in_window(input logic [7:0] a);
        in_window = (a >= OFS_DIV) && (a <= OFS_TMIN_L);
    endfunction

    // Greater-or-equal so a shorter length written mid-count ends it at once
    function automatic logic at_end(input logic [9:0] cnt, input logic [9:0] len);
        at_end = (cnt >= len - 10'h001);
    endfunction

    // One channel per measured source, same comparator for each
    sartd_cmp_if a1_if();
    sartd_cmp_if a2_if();
    sartd_cmp_if t_if();

    assign a1_if.max_en = regs_r[OFS_A1MAX_H][ENA_BIT];
    assign a1_if.max_thr = thr(regs_r[OFS_A1MAX_H], regs_r[OFS_A1MAX_L]);
    assign a1_if.min_en = regs_r[OFS_A1MIN_H][ENA_BIT];
    assign a1_if.min_thr = thr(regs_r[OFS_A1MIN_H], regs_r[OFS_A1MIN_L]);
    assign a1_if.sample = conv_data;
    assign a1_if.strobe = conv_done && (conv_src == SARTD_SRC_FIRST_AUX);
    assign a2_if.max_en = regs_r[OFS_A2MAX_H][ENA_BIT];
    assign a2_if.max_thr = thr(regs_r[OFS_A2MAX_H], regs_r[OFS_A2MAX_L]);
    assign a2_if.min_en = regs_r[OFS_A2MIN_H][ENA_BIT];
    assign a2_if.min_thr = thr(regs_r[OFS_A2MIN_H], regs_r[OFS_A2MIN_L]);
    assign a2_if.sample = conv_data;
    assign a2_if.strobe = conv_done && (conv_src == SARTD_SRC_SECOND_AUX);
    // Either sensor lands here; the scan logic picks which one converts
    assign t_if.max_en = regs_r[OFS_TMAX_H][ENA_BIT];
    assign t_if.max_thr = thr(regs_r[OFS_TMAX_H], regs_r[OFS_TMAX_L]);
    assign t_if.min_en = regs_r[OFS_TMIN_H][ENA_BIT];
    assign t_if.min_thr = thr(regs_r[OFS_TMIN_H], regs_r[OFS_TMIN_L]);
    assign t_if.sample = conv_data;
    assign t_if.strobe = conv_done && (conv_src == SARTD_SRC_TEMP);

    sartd_cmp u_a1 (.ch(a1_if));
    sartd_cmp u_a2 (.ch(a2_if));
    sartd_cmp u_t (.ch(t_if));

    // Register file and sticky flags
    assign flag_read = reg_rd && (reg_addr == OFS_FLAGS);
    // Flag register holds no stored byte; writes there are dropped
    assign reg_write = reg_wr && in_window(reg_addr) && (reg_addr != OFS_FLAGS);
    always_comb begin
        logic [5:0] hits;
        hits = '0;
        regs_nxt = regs_r;
        flags_nxt = flags_r;
        rdata_nxt = rdata_r;
        hits[FLG_A1MAX] = a1_if.hit_max;
        hits[FLG_A1MIN] = a1_if.hit_min;
        hits[FLG_A2MAX] = a2_if.hit_max;
        hits[FLG_A2MIN] = a2_if.hit_min;
        hits[FLG_TMAX] = t_if.hit_max;
        hits[FLG_TMIN] = t_if.hit_min;
        if (reg_rd) begin
            if (in_window(reg_addr)) begin
                rdata_nxt = regs_r[reg_addr];
            end else begin
                rdata_nxt = 8'h00;
            end
        end
        // Reserved bits 7:6 always read back as zero
        if (flag_read) begin
            rdata_nxt = {2'b00, flags_r};
            flags_nxt = 6'h00;
        end
        // Set after clear so an event in the read cycle survives
        flags_nxt = flags_nxt | hits;
        if (reg_write) begin
            regs_nxt[reg_addr] = reg_wdata;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = OFS_DIV; i <= OFS_TMIN_L; i++) begin
                regs_r[i] <= RST_REG;
            end
            // Divider resets to one, every other byte to zero
            regs_r[OFS_DIV] <= {1'b0, RST_DIV};
            flags_r <= 6'h00;
            rdata_r <= 8'h00;
        end else begin
            regs_r <= regs_nxt;
            flags_r <= flags_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Debounce time base and counter
    assign code = regs_r[OFS_PEN_DB][DB_CODE_LSB +: DB_CODE_W];
    // Zero divider code stands for the largest ratio
    assign div_len = (regs_r[OFS_DIV][6:0] == 7'h00) ? 8'(DIV_ZERO_RATIO)
        : {1'b0, regs_r[OFS_DIV][6:0]};
    assign us_tick = osc_sel ? osc_tick : at_end({3'h0, div_cnt_r}, {2'h0, div_len});
    // Tick every duration/8: base 8 units at code 001, doubling per code
    assign pre_len = 10'((DB_BASE_US / DB_TICKS) << (code - 3'h1));
    assign db_tick = us_tick && at_end(pre_cnt_r, pre_len);

    always_comb begin
        // Three stages; a level counts once stages two and three agree
        pen_sync_nxt = {pen_sync_r[1:0], pen_raw};
        pen_state_nxt = pen_state_r;
        if (pen_sync_r[2] == pen_sync_r[1]) begin
            pen_state_nxt = pen_sync_r[2];
        end
        div_cnt_nxt = div_cnt_r;
        if (!osc_sel) begin
            div_cnt_nxt = us_tick ? 7'h00 : div_cnt_r + 7'h01;
        end
        pre_cnt_nxt = pre_cnt_r;
        tick_cnt_nxt = tick_cnt_r;
        pen_out_nxt = pen_out_r;
        // Any drop of the settled pen restarts the whole count
        if (!pen_state_r) begin
            pre_cnt_nxt = 10'h000;
            tick_cnt_nxt = 4'h0;
            pen_out_nxt = 1'b0;
        end else if (code == 3'h0) begin
            pen_out_nxt = 1'b1;
        end else if (!pen_out_r && us_tick) begin
            pre_cnt_nxt = db_tick ? 10'h000 : pre_cnt_r + 10'h001;
            if (db_tick) begin
                tick_cnt_nxt = tick_cnt_r + 4'h1;
                if (tick_cnt_r == 4'(DB_TICKS - 1)) begin
                    pen_out_nxt = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pen_sync_r <= 3'h0;
            pen_state_r <= 1'b0;
            div_cnt_r <= 7'h00;
            pre_cnt_r <= 10'h000;
            tick_cnt_r <= 4'h0;
            pen_out_r <= 1'b0;
        end else begin
            pen_sync_r <= pen_sync_nxt;
            pen_state_r <= pen_state_nxt;
            div_cnt_r <= div_cnt_nxt;
            pre_cnt_r <= pre_cnt_nxt;
            tick_cnt_r <= tick_cnt_nxt;
            pen_out_r <= pen_out_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign pen_down = pen_out_r;
    assign flags = flags_r;
endmodule

// >>> sim/sartd_chk.sv
// Checker: port-level assertions of the threshold and debounce block
`timescale 1ns/100ps
module sartd_chk
    import sartd_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pen and conversion
    input wire logic pen_raw,
    input wire logic pen_down,
    input wire logic conv_done,
    input wire sartd_pkg::sartd_src_e conv_src,
    input wire logic [5:0] flags
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic frd;
    assign frd = reg_rd && reg_addr == OFS_FLAGS;
    // Set wins over clear, so only a read without conversion must empty the flags
    a_read_clears: assert property (frd && !conv_done |=> flags == 6'h00)
        else $error("flags not cleared by read");
    a_flags_sticky: assert property (!frd |=> (flags & $past(flags)) == $past(flags))
        else $error("flag dropped without read");
    a_set_on_conv: assert property (!conv_done |=> (flags & ~$past(flags)) == 6'h00)
        else $error("flag set without conversion");
    a_first_aux_bits: assert property (conv_done && conv_src == SARTD_SRC_FIRST_AUX && !frd
        |=> (flags & 6'h0F) == ($past(flags) & 6'h0F)) else $error("first aux touched other flags");
    a_second_aux_bits: assert property (conv_done && conv_src == SARTD_SRC_SECOND_AUX && !frd
        |=> (flags & 6'h33) == ($past(flags) & 6'h33)) else $error("second aux touched other flags");
    a_temp_bits: assert property (conv_done && conv_src == SARTD_SRC_TEMP && !frd
        |=> (flags & 6'h3C) == ($past(flags) & 6'h3C)) else $error("temp touched other flags");
    a_unmapped_zero: assert property (reg_rd && (reg_addr < 8'h10 || reg_addr > 8'h21)
        ##1 !reg_rd |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_rdata_stands: assert property (!reg_rd && !$past(reg_rd) |=> $stable(reg_rdata))
        else $error("read data moved without read");
    a_pen_release: assert property (!pen_raw [*6] |-> !pen_down)
        else $error("pen_down held after release");
    a_pen_qualify: assert property ($rose(pen_down)
        |-> $past(pen_raw) && $past(pen_raw, 2) && $past(pen_raw, 3)) else $error("early pen_down");
    c_flag_read: cover property (frd && flags != 6'h00);
    c_pen_down: cover property ($rose(pen_down));
    c_temp_conv: cover property (conv_done && conv_src == SARTD_SRC_TEMP);
endmodule
bind sartd_top sartd_chk i_chk (.clk, .sys_rst, .reg_addr, .reg_rd, .reg_rdata, .pen_raw,
    .pen_down, .conv_done, .conv_src, .flags);

// >>> sim/tb_top.sv
// Testbench: registers, threshold flags and pen-down debounce
`timescale 1ns/100ps
module tb_top;
    import sartd_pkg::*;
    logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, osc_sel = 0, osc_tick = 0;
    logic pen_raw = 0, pen_down, conv_done = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [11:0] conv_data = 12'h000;
    logic [5:0] flags;
    logic [1:0] tc = 2'h0;
    sartd_src_e conv_src = SARTD_SRC_FIRST_AUX;
    int num_errors = 0, n_checks = 0;
    always #10 clk = ~clk;
    // Oscillator stand-in: one tick every third cycle
    always @(negedge clk) begin
        tc <= (tc == 2'h2) ? 2'h0 : tc + 2'h1;
        osc_tick <= (tc == 2'h0);
    end
    sartd_top i_dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .osc_sel, .osc_tick, .pen_raw, .pen_down, .conv_done, .conv_src, .conv_data, .flags);
    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic chk1(input string n, input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s exp %b got %b", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        @(negedge clk);
        reg_wr = 0;
    endtask
    // Waits a spare cycle so either read latency is judged fairly
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1;
        @(negedge clk);
        reg_rd = 0;
        @(negedge clk);
        chk8($sformatf("reg_%h", a), e, reg_rdata);
    endtask
    task automatic conv(input sartd_src_e s, input logic [11:0] d);
        @(negedge clk);
        conv_src = s;
        conv_data = d;
        conv_done = 1;
        @(negedge clk);
        conv_done = 0;
    endtask
    task automatic t_regs;
        rd(8'h10, 8'h01);
        for (logic [7:0] a = 8'h14; a <= 8'h18; a++) rd(a, 8'h00);
        wr(8'h40, 8'h5A);
        rd(8'h40, 8'h00);
        $display("t_regs done");
    endtask
    task automatic t_thr;
        wr(8'h16, 8'h1A);
        wr(8'h17, 8'h00);
        rd(8'h16, 8'h1A);
        conv(SARTD_SRC_FIRST_AUX, 12'h9FF);
        rd(8'h15, 8'h00);
        conv(SARTD_SRC_FIRST_AUX, 12'hA00);
        chk8("flags", 8'h20, {2'h0, flags});
        rd(8'h15, 8'h20);
        rd(8'h15, 8'h00);
        conv(SARTD_SRC_SECOND_AUX, 12'hFFF);
        conv(SARTD_SRC_TEMP, 12'h000);
        rd(8'h15, 8'h00);
        wr(8'h18, 8'h11);
        wr(8'h19, 8'h00);
        conv(SARTD_SRC_FIRST_AUX, 12'h101);
        conv(SARTD_SRC_FIRST_AUX, 12'h100);
        rd(8'h15, 8'h10);
        wr(8'h1A, 8'h10);
        wr(8'h1C, 8'h1F);
        wr(8'h1D, 8'hFF);
        conv(SARTD_SRC_SECOND_AUX, 12'h7FF);
        rd(8'h15, 8'h0C);
        wr(8'h1E, 8'h17);
        wr(8'h1F, 8'hFF);
        wr(8'h20, 8'h17);
        wr(8'h21, 8'hFE);
        conv(SARTD_SRC_TEMP, 12'h7FF);
        conv(SARTD_SRC_TEMP, 12'h7FE);
        rd(8'h15, 8'h03);
        wr(8'h15, 8'h3F);
        rd(8'h15, 8'h00);
        $display("t_thr done");
    endtask
    // Tick phase is unknown, so eight ticks may land after seven periods
    task automatic t_pen(input logic [2:0] c, input logic o, input int nom, input logic g);
        int n;
        n = 0;
        wr(8'h14, {5'h00, c});
        osc_sel = o;
        pen_raw = 1;
        if (g) begin
            repeat (nom / 2) @(negedge clk);
            pen_raw = 0;
            repeat (6) @(negedge clk);
            pen_raw = 1;
        end
        while (pen_down !== 1'b1 && n < nom + 40) begin
            @(negedge clk);
            n++;
        end
        chk1("pen_late", 1'b1, n < nom + 40);
        chk1("pen_early", 1'b1, n * 8 + 64 >= nom * 7);
        pen_raw = 0;
        repeat (8) @(negedge clk);
        chk1("pen_up", 1'b0, pen_down);
        $display("t_pen code %0d done", c);
        if (n >= nom + 40) test_done;
    endtask
    initial begin
        repeat (12) @(negedge clk);
        sys_rst = 0;
        t_regs;
        t_thr;
        wr(8'h10, 8'h02);
        t_pen(3'h0, 1'b0, 0, 1'b0);
        t_pen(3'h1, 1'b0, 128, 1'b1);
        t_pen(3'h3, 1'b0, 512, 1'b0);
        t_pen(3'h1, 1'b1, 192, 1'b0);
        wr(8'h10, 8'h00);
        t_pen(3'h1, 1'b0, 8192, 1'b0);
        test_done;
    end
endmodule
